/* aac_fs_tick.sv */
// Sample-rate enable divider: one-cycle tick every DIV core clocks.
// Assumes a synchronised active-low reset.
module aac_fs_tick #(
    parameter int DIV = aac_pkg::FS_DIV
) (
    input  wire logic core_clk,
    input  wire logic rst_n,
    output logic      tick
);
    import aac_pkg::*;

    localparam int CNT_W = $clog2(DIV);
    localparam logic [CNT_W-1:0] LAST = CNT_W'(DIV - 1);

    generate
        if (DIV < 2) begin : g_bad_div
            $error("aac_fs_tick: DIV must be at least 2");
        end
    endgenerate

    logic [CNT_W-1:0] cnt_r;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= '0;
            tick  <= 1'b0;
        end else begin
            tick  <= (cnt_r == LAST);
            cnt_r <= (cnt_r == LAST) ? '0 : CNT_W'(cnt_r + 1'b1);
        end
    end

    // Ticks never come back to back
    tick_spacing_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        tick |=> !tick [*1] ##0 (cnt_r == CNT_W'(1)))
        else $error("fs tick spacing wrong");

endmodule

/* aac_gain_ramp.sv */
// Soft-step ramp: moves the applied gain toward the target one 0.5 dB code per one or two sample intervals.
// Assumes the target is already clamped and the tick comes from the sample-rate divider.
module aac_gain_ramp (
    input  wire logic core_clk,
    input  wire logic rst_n,
    aac_step_if.ramp  stp
);
    import aac_pkg::*;

    logic half_r;

    function automatic aac_gain_t step_toward(input aac_gain_t cur, input aac_gain_t tgt);
        if (cur < tgt)
            step_toward = GAIN_W'(cur + GAIN_ONE);
        else if (cur > tgt)
            step_toward = GAIN_W'(cur - GAIN_ONE);
        else
            step_toward = cur;
    endfunction

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            stp.applied <= '0;
            half_r      <= 1'b0;
        end else begin
            case (stp.rate)
                STEP_EACH_FS: begin
                    half_r <= 1'b0;
                    if (stp.tick)
                        stp.applied <= step_toward(stp.applied, stp.target);
                end
                STEP_TWO_FS: begin
                    if (stp.tick) begin
                        half_r <= ~half_r;
                        if (half_r)
                            stp.applied <= step_toward(stp.applied, stp.target);
                    end
                end
                default: begin
                    half_r      <= 1'b0;
                    stp.applied <= stp.target;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    step_each_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (stp.rate == STEP_EACH_FS && stp.tick && stp.applied < stp.target)
        |=> (stp.applied == GAIN_W'($past(stp.applied) + GAIN_ONE)))
        else $error("soft step per sample did not advance by one");

    step_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (stp.rate != STEP_OFF_A && stp.rate != STEP_OFF_B && !stp.tick) |=> $stable(stp.applied))
        else $error("applied gain moved without a sample tick");

    step_off_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (stp.rate == STEP_OFF_A || stp.rate == STEP_OFF_B) |=> (stp.applied == $past(stp.target)))
        else $error("disabled soft step did not apply target at once");

endmodule

/* aac_input_mix_regs.sv */
// Record-path front-end registers: right PGA gain and mute, aux mic levels into both ADC mixers,
// first left line input mode, level, left ADC power and left PGA soft-step rate.
// Assumes a control-bus front end on core_clk presenting one-cycle read and write strobes.
module aac_input_mix_regs #(
    parameter int FS_DIV = aac_pkg::FS_DIV
) (
    input  wire logic            core_clk,
    input  wire logic            resetn,
    input  wire logic            reg_wr,
    input  wire logic            reg_rd,
    input  wire aac_pkg::aac_addr_t reg_addr,
    input  wire aac_pkg::aac_data_t reg_wdata,
    output aac_pkg::aac_data_t   reg_rdata,
    output logic                 reg_rvalid,
    input  wire aac_pkg::aac_gain_t left_gain_target,
    output logic                 right_pga_mute,
    output aac_pkg::aac_gain_t   right_pga_gain,
    output aac_pkg::aac_lvl_t    aux_mic_in_left_to_left_level,
    output logic                 aux_mic_in_left_to_left_conn,
    output aac_pkg::aac_lvl_t    aux_mic_in_right_to_left_level,
    output logic                 aux_mic_in_right_to_left_conn,
    output aac_pkg::aac_lvl_t    aux_mic_in_left_to_right_level,
    output logic                 aux_mic_in_left_to_right_conn,
    output aac_pkg::aac_lvl_t    aux_mic_in_right_to_right_level,
    output logic                 aux_mic_in_right_to_right_conn,
    output logic                 line_in_first_left_diff,
    output aac_pkg::aac_lvl_t    line_in_first_left_level,
    output logic                 line_in_first_left_conn,
    output logic                 left_adc_power,
    output aac_pkg::aac_gain_t   left_gain_applied
);
    import aac_pkg::*;

    generate
        if (FS_DIV < 2) begin : g_bad_fs_div
            $error("aac_input_mix_regs: FS_DIV must be at least 2");
        end
    endgenerate

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic rst_meta_r;
    logic rst_n;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rst_meta_r <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n      <= rst_meta_r;
        end
    end

    // ------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------
    aac_data_t right_gain_r;
    aac_data_t aux_left_r;
    aac_data_t aux_right_r;
    aac_data_t line1_r;

    logic wr_right;
    logic wr_aux_l;
    logic wr_aux_r;
    logic wr_line1;

    assign wr_right = reg_wr && (reg_addr == ADDR_RIGHT_GAIN);
    assign wr_aux_l = reg_wr && (reg_addr == ADDR_AUX_LEFT);
    assign wr_aux_r = reg_wr && (reg_addr == ADDR_AUX_RIGHT);
    assign wr_line1 = reg_wr && (reg_addr == ADDR_LINE1_LEFT);

    // All bits stored as written; reserved level codes are the writer's problem
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            right_gain_r <= RIGHT_GAIN_RST;
            aux_left_r   <= AUX_LEVEL_RST;
            aux_right_r  <= AUX_LEVEL_RST;
            line1_r      <= LINE1_RST;
        end else begin
            if (wr_right)
                right_gain_r <= reg_wdata;
            if (wr_aux_l)
                aux_left_r <= reg_wdata;
            if (wr_aux_r)
                aux_right_r <= reg_wdata;
            if (wr_line1)
                line1_r <= reg_wdata;
        end
    end

    // ------------------------------------------------------------
    // Read-back
    // ------------------------------------------------------------
    aac_data_t rd_mux;

    always_comb begin
        case (reg_addr)
            ADDR_RIGHT_GAIN: rd_mux = right_gain_r;
            ADDR_AUX_LEFT:   rd_mux = aux_left_r;
            ADDR_AUX_RIGHT:  rd_mux = aux_right_r;
            ADDR_LINE1_LEFT: rd_mux = line1_r;
            default:         rd_mux = UNMAPPED_READ;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata  <= UNMAPPED_READ;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            if (reg_rd)
                reg_rdata <= rd_mux;
        end
    end

    // ------------------------------------------------------------
    // Field decode to analog controls
    // ------------------------------------------------------------
    // Registered once more so every control pin is glitch-free toward the analog side
    aac_lvl_t f_aux_ll;
    aac_lvl_t f_aux_rl;
    aac_lvl_t f_aux_lr;
    aac_lvl_t f_aux_rr;
    aac_lvl_t f_line;

    assign f_aux_ll = aux_left_r[LVL_HI_LSB +: LVL_W];
    assign f_aux_rl = aux_left_r[LVL_LO_LSB +: LVL_W];
    assign f_aux_lr = aux_right_r[LVL_HI_LSB +: LVL_W];
    assign f_aux_rr = aux_right_r[LVL_LO_LSB +: LVL_W];
    assign f_line   = line1_r[LINE_LVL_LSB +: LVL_W];

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            right_pga_mute <= 1'b1;
            right_pga_gain <= '0;
        end else begin
            right_pga_mute <= right_gain_r[MUTE_BIT];
            right_pga_gain <= clamp_gain(right_gain_r[GAIN_MSB:0]);
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            aux_mic_in_left_to_left_level   <= LVL_OFF;
            aux_mic_in_left_to_left_conn    <= 1'b0;
            aux_mic_in_right_to_left_level  <= LVL_OFF;
            aux_mic_in_right_to_left_conn   <= 1'b0;
            aux_mic_in_left_to_right_level  <= LVL_OFF;
            aux_mic_in_left_to_right_conn   <= 1'b0;
            aux_mic_in_right_to_right_level <= LVL_OFF;
            aux_mic_in_right_to_right_conn  <= 1'b0;
        end else begin
            aux_mic_in_left_to_left_level   <= f_aux_ll;
            aux_mic_in_left_to_left_conn    <= lvl_conn(f_aux_ll);
            aux_mic_in_right_to_left_level  <= f_aux_rl;
            aux_mic_in_right_to_left_conn   <= lvl_conn(f_aux_rl);
            aux_mic_in_left_to_right_level  <= f_aux_lr;
            aux_mic_in_left_to_right_conn   <= lvl_conn(f_aux_lr);
            aux_mic_in_right_to_right_level <= f_aux_rr;
            aux_mic_in_right_to_right_conn  <= lvl_conn(f_aux_rr);
        end
    end

    // Mode pin is per connection; keeping both channels matched is left to software
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            line_in_first_left_diff  <= 1'b0;
            line_in_first_left_level <= LVL_OFF;
            line_in_first_left_conn  <= 1'b0;
            left_adc_power           <= 1'b0;
        end else begin
            line_in_first_left_diff  <= line1_r[LINE_DIFF_BIT];
            line_in_first_left_level <= f_line;
            line_in_first_left_conn  <= lvl_conn(f_line);
            left_adc_power           <= line1_r[POWER_BIT];
        end
    end

    // ------------------------------------------------------------
    // Left PGA soft-stepping
    // ------------------------------------------------------------
    logic fs_tick;

    aac_step_if stp ();

    aac_fs_tick #(
        .DIV (FS_DIV)
    ) u_fs_tick (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .tick     (fs_tick)
    );

    assign stp.target = clamp_gain(left_gain_target);
    assign stp.rate   = aac_step_rate_t'(line1_r[STEP_LSB +: 2]);
    assign stp.tick   = fs_tick;

    aac_gain_ramp u_ramp (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .stp      (stp)
    );

    assign left_gain_applied = stp.applied;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence wr_to(aac_addr_t a);
        reg_wr && (reg_addr == a);
    endsequence

    sequence rd_from(aac_addr_t a);
        reg_rd && !reg_wr && (reg_addr == a);
    endsequence

    property settle_two(aac_addr_t a, logic ok);
        @(posedge core_clk) disable iff (!rst_n)
        wr_to(a) ##1 !reg_wr [*1] |=> ok;
    endproperty

    right_mute_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        wr_to(ADDR_RIGHT_GAIN) ##1 !reg_wr |=> (right_pga_mute == $past(reg_wdata[MUTE_BIT], 2)))
        else $error("right mute does not follow written bit");

    right_gain_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (wr_to(ADDR_RIGHT_GAIN) and (reg_wdata[GAIN_MSB:0] <= GAIN_MAX)) ##1 !reg_wr
        |=> (right_pga_gain == $past(reg_wdata[GAIN_MSB:0], 2)))
        else $error("right gain code not passed through");

    right_sat_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (wr_to(ADDR_RIGHT_GAIN) and (reg_wdata[GAIN_MSB:0] > GAIN_MAX)) ##1 !reg_wr
        |=> (right_pga_gain == GAIN_MAX))
        else $error("right gain not saturated at maximum");

    aux_ll_level_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        wr_to(ADDR_AUX_LEFT) ##1 !reg_wr
        |=> (aux_mic_in_left_to_left_level == $past(reg_wdata[LVL_HI_LSB +: LVL_W], 2)))
        else $error("left aux level into left mixer wrong");

    aux_rl_conn_a: assert property (settle_two(ADDR_AUX_LEFT,
        (aux_mic_in_right_to_left_level == $past(reg_wdata[LVL_LO_LSB +: LVL_W], 2)) &&
        (aux_mic_in_right_to_left_conn == ($past(reg_wdata[LVL_LO_LSB +: LVL_W], 2) != LVL_OFF))))
        else $error("right aux into left mixer wrong");

    aux_lr_conn_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        wr_to(ADDR_AUX_RIGHT) ##1 !reg_wr
        |=> (aux_mic_in_left_to_right_level == $past(reg_wdata[LVL_HI_LSB +: LVL_W], 2)) &&
            (aux_mic_in_left_to_right_conn == ($past(reg_wdata[LVL_HI_LSB +: LVL_W], 2) != LVL_OFF)))
        else $error("left aux into right mixer wrong");

    aux_rr_conn_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        wr_to(ADDR_AUX_RIGHT) ##1 !reg_wr
        |=> (aux_mic_in_right_to_right_conn == ($past(reg_wdata[LVL_LO_LSB +: LVL_W], 2) != LVL_OFF)))
        else $error("right aux connect into right mixer wrong");

    line_conn_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        wr_to(ADDR_LINE1_LEFT) ##1 !reg_wr
        |=> (line_in_first_left_conn == ($past(reg_wdata[LINE_LVL_LSB +: LVL_W], 2) != LVL_OFF)))
        else $error("line input connect wrong");

    line_mode_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        wr_to(ADDR_LINE1_LEFT) ##1 !reg_wr
        |=> (line_in_first_left_diff == $past(reg_wdata[LINE_DIFF_BIT], 2)))
        else $error("line input mode wrong");

    line_level_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        wr_to(ADDR_LINE1_LEFT) ##1 !reg_wr
        |=> (line_in_first_left_level == $past(reg_wdata[LINE_LVL_LSB +: LVL_W], 2)))
        else $error("line input level wrong");

    adc_power_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        wr_to(ADDR_LINE1_LEFT) ##1 !reg_wr |=> (left_adc_power == $past(reg_wdata[POWER_BIT], 2)))
        else $error("left ADC power wrong");

    step_rate_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        rd_from(ADDR_LINE1_LEFT) |=> reg_rvalid && (reg_rdata[STEP_LSB +: 2] == stp.rate))
        else $error("soft-step rate readback mismatch");

    unmapped_rd_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (reg_rd && reg_addr != ADDR_RIGHT_GAIN && reg_addr != ADDR_AUX_LEFT &&
         reg_addr != ADDR_AUX_RIGHT && reg_addr != ADDR_LINE1_LEFT)
        |=> reg_rvalid && (reg_rdata == UNMAPPED_READ))
        else $error("unmapped read not zero");

endmodule

/* aac_input_mix_regs_tb.sv */
// Self-checking bench for the record-path input mix and gain registers.
// Assumes aac_pkg and the design files are compiled first; the design sees a shortened sample interval.
`define CHK(nm, ex, gt) begin checks_done++; if ((gt) !== (ex)) begin mismatches++; \
    $display("mismatch %s expected %h seen %h", nm, ex, gt); end end
module aac_input_mix_regs_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import aac_pkg::*;
    localparam int FSD = 4;
    logic      core_clk = 0, resetn = 0, reg_wr = 0, reg_rd = 0, reg_rvalid, mute, diff, line_conn, power;
    aac_addr_t reg_addr = '0, a;
    aac_data_t reg_wdata = '0, reg_rdata, d;
    aac_gain_t left_gain_target = '0, right_gain, applied;
    aac_lvl_t  lvl [4];
    aac_lvl_t  line_lvl;
    logic      conn [4];
    aac_data_t mdl [4] = '{8'h80, 8'hFF, 8'hFF, 8'h78};
    int        mismatches = 0, checks_done = 0, i;
    int        seed = 32'h6bf9d68b;

    aac_input_mix_regs #(.FS_DIV(FSD)) dut_u (.core_clk(core_clk), .resetn(resetn), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .left_gain_target(left_gain_target), .right_pga_mute(mute),
        .right_pga_gain(right_gain), .aux_mic_in_left_to_left_level(lvl[0]), .aux_mic_in_left_to_left_conn(conn[0]),
        .aux_mic_in_right_to_left_level(lvl[1]), .aux_mic_in_right_to_left_conn(conn[1]),
        .aux_mic_in_left_to_right_level(lvl[2]), .aux_mic_in_left_to_right_conn(conn[2]),
        .aux_mic_in_right_to_right_level(lvl[3]), .aux_mic_in_right_to_right_conn(conn[3]),
        .line_in_first_left_diff(diff), .line_in_first_left_level(line_lvl), .line_in_first_left_conn(line_conn),
        .left_adc_power(power), .left_gain_applied(applied));

    always #50 core_clk = ~core_clk;

    // ------------------------------------------------------------
    // Bus tasks and model comparison
    // ------------------------------------------------------------
    task automatic wr(input aac_addr_t ad, input aac_data_t dt);
        reg_addr = ad;
        reg_wdata = dt;
        reg_wr = 1'b1;
        @(posedge core_clk);
        #1 reg_wr = 1'b0;
        if (ad inside {[7'h10:7'h13]}) mdl[ad - 7'h10] = dt;
    endtask

    // Read answer is due exactly one cycle after the strobe and stands one cycle
    task automatic rd(input aac_addr_t ad);
        reg_addr = ad;
        reg_rd = 1'b1;
        @(posedge core_clk);
        #1 reg_rd = 1'b0;
        `CHK("rvalid", 1'b1, reg_rvalid)
        `CHK("rdata", (ad inside {[7'h10:7'h13]}) ? mdl[ad - 7'h10] : 8'h00, reg_rdata)
        @(posedge core_clk);
        #1;
        `CHK("rvalid drop", 1'b0, reg_rvalid)
    endtask

    task automatic chk_all;
        aac_lvl_t e;
        `CHK("mute", mdl[0][7], mute)
        `CHK("gain", (mdl[0][6:0] > 7'h77) ? 7'h77 : mdl[0][6:0], right_gain)
        for (int k = 0; k < 4; k++) begin
            e = mdl[1 + k / 2][7 - 4 * (k % 2) -: 4];
            `CHK("aux level", e, lvl[k])
            `CHK("aux conn", e !== 4'hF, conn[k])
        end
        `CHK("line diff", mdl[3][7], diff)
        `CHK("line level", mdl[3][6:3], line_lvl)
        `CHK("line conn", mdl[3][6:3] !== 4'hF, line_conn)
        `CHK("adc power", mdl[3][2], power)
    endtask

    // Reserved level codes are never produced
    function automatic aac_lvl_t lv();
        int r;
        r = $unsigned($random(seed)) % 10;
        lv = (r == 9) ? 4'hF : 4'(r);
    endfunction

    // ------------------------------------------------------------
    // Soft-step ramp: at rates 0 and 1 each step one code, spaced by whole intervals; rates 2 and 3 jump at once
    // ------------------------------------------------------------
    task automatic ramp(input logic [1:0] rt, input aac_gain_t tg);
        int n, last;
        aac_gain_t prev, e;
        wr(7'h13, {mdl[3][7:2], rt});
        repeat (2) @(posedge core_clk);
        #1 left_gain_target = tg;
        e = (tg > 7'h77) ? 7'h77 : tg;
        prev = applied;
        last = 0;
        for (n = 1; n < 400 && applied !== e; n++) begin
            @(posedge core_clk);
            #1;
            if (applied !== prev && !rt[1]) begin
                `CHK("step", (prev < e) ? prev + 7'h01 : prev - 7'h01, applied)
                if (last > 0) `CHK("step gap", (rt == 2'h0) ? FSD : 2 * FSD, n - last)
                last = n;
                prev = applied;
            end
        end
        if (rt[1]) `CHK("instant", 1'b1, n <= 2)
        `CHK("ramp end", e, applied)
        $display("test ramp rate %0d done", rt);
    endtask

    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        #500000;
        mismatches++;
        finish_test();
    end

    initial begin
        repeat (16) @(posedge core_clk);
        #1 resetn = 1'b1;
        repeat (3) @(posedge core_clk);
        #1 chk_all();
        for (i = 0; i < 5; i++) rd(7'h10 + 7'(i));
        $display("test reset done");
        for (i = 0; i < 40; i++) begin
            a = (i < 3) ? 7'h10 : 7'h10 + 7'($unsigned($random(seed)) % 5);
            d = 8'($random(seed));
            if (i < 3) d = 8'h76 + 8'(i);
            else if (a == 7'h11 || a == 7'h12) d = {lv(), lv()};
            else if (a == 7'h13) d = {d[7], lv(), d[2:0]};
            wr(a, d);
            @(posedge core_clk);
            #1 chk_all();
            rd(a);
        end
        $display("test random writes done");
        ramp(2'h2, 7'h7A);
        ramp(2'h0, 7'h70);
        ramp(2'h1, 7'h74);
        ramp(2'h3, 7'h05);
        ramp(2'h0, 7'h08);
        // Mid-run reset: registers and outputs fall back to reset values
        resetn = 1'b0;
        mdl = '{8'h80, 8'hFF, 8'hFF, 8'h78};
        repeat (2) @(posedge core_clk);
        #1 resetn = 1'b1;
        repeat (3) @(posedge core_clk);
        #1 chk_all();
        `CHK("applied rst", 7'h00, applied)
        rd(7'h13);
        $display("test mid-run reset done");
        finish_test();
    end
endmodule

/* aac_pkg.sv */
// Shared constants, types and helpers for the record-path input mix and gain registers.
// Assumes a single 10 MHz core clock and a register port fed by the codec control-bus front end.
package aac_pkg;

    // ------------------------------------------------------------
    // Widths and types
    // ------------------------------------------------------------
    localparam int ADDR_W = 7;
    localparam int DATA_W = 8;
    localparam int GAIN_W = 7;
    localparam int LVL_W  = 4;

    typedef logic [ADDR_W-1:0] aac_addr_t;
    typedef logic [DATA_W-1:0] aac_data_t;
    typedef logic [GAIN_W-1:0] aac_gain_t;
    typedef logic [LVL_W-1:0]  aac_lvl_t;

    typedef enum logic [1:0] {
        STEP_EACH_FS = 2'h0,
        STEP_TWO_FS  = 2'h1,
        STEP_OFF_A   = 2'h2,
        STEP_OFF_B   = 2'h3
    } aac_step_rate_t;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam aac_addr_t ADDR_RIGHT_GAIN = 7'h10;
    localparam aac_addr_t ADDR_AUX_LEFT   = 7'h11;
    localparam aac_addr_t ADDR_AUX_RIGHT  = 7'h12;
    localparam aac_addr_t ADDR_LINE1_LEFT = 7'h13;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam aac_data_t RIGHT_GAIN_RST = 8'h80;
    localparam aac_data_t AUX_LEVEL_RST  = 8'hFF;
    localparam aac_data_t LINE1_RST      = 8'h78;
    localparam aac_data_t UNMAPPED_READ  = 8'h00;

    // ------------------------------------------------------------
    // Field positions and codes
    // ------------------------------------------------------------
    localparam int MUTE_BIT      = 7;
    localparam int GAIN_MSB      = 6;
    localparam int LVL_HI_LSB    = 4;
    localparam int LVL_LO_LSB    = 0;
    localparam int LINE_DIFF_BIT = 7;
    localparam int LINE_LVL_LSB  = 3;
    localparam int POWER_BIT     = 2;
    localparam int STEP_LSB      = 0;

    localparam aac_lvl_t  LVL_OFF  = 4'hF;
    localparam aac_gain_t GAIN_MAX = 7'h77;
    localparam aac_gain_t GAIN_ONE = 7'h01;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_HZ         = 10_000_000;
    localparam int SAMPLE_RATE_HZ = 48_000;
    localparam int FS_DIV         = CLK_HZ / SAMPLE_RATE_HZ;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic aac_gain_t clamp_gain(input aac_gain_t g);
        clamp_gain = (g > GAIN_MAX) ? GAIN_MAX : g;
    endfunction

    function automatic logic lvl_conn(input aac_lvl_t c);
        lvl_conn = (c != LVL_OFF);
    endfunction

endpackage

/* aac_step_if.sv */
// Carrier between the register top and the soft-step gain ramp.
// Assumes both ends sit on the same core clock.
interface aac_step_if;
    import aac_pkg::*;

    aac_gain_t      target;
    aac_step_rate_t rate;
    logic           tick;
    aac_gain_t      applied;

    modport ctrl (output target, output rate, output tick, input applied);
    modport ramp (input target, input rate, input tick, output applied);
endinterface
